// >>> hdl/dtcd_top.sv
`timescale 1ns/1ps
// drive terminal command decoder with apb register access
module dtcd_top #(
   parameter int MS_CYCLES = dtcd_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // terminal pins, asynchronous
   input wire dtcd_pkg::dtcd_term_type terminalIn,
   // decoded outputs
   output dtcd_pkg::dtcd_cmd_type runCommand,
   output dtcd_pkg::dtcd_sel_type selection,
   output logic [15:0] refFrequency,
   output logic [15:0] pidSetpoint,
   output logic [15:0] vfVoltage
);
   localparam int NIN = $bits(dtcd_pkg::dtcd_term_type);

   // configuration registers
   logic [1:0] commandMode;
   logic freqSrcMulti;
   logic pidSrcMulti;
   logic vfSrcMulti;
   logic [9:0] filterTime;
   logic [15:0] maxFrequency;

   // terminal path
   logic [NIN-1:0] syncFirst;
   logic [NIN-1:0] syncSecond;
   logic [NIN-1:0] filtered;
   logic [9:0] holdCount [NIN];
   logic [15:0] msCount;
   logic msTick;
   dtcd_pkg::dtcd_term_type term;

   // command path
   logic [1:0] effMode;
   logic threeLine;
   logic prevRunFwd;
   logic prevDirRev;
   logic fwdPress;
   logic revPress;
   dtcd_pkg::dtcd_latch_type latchState;
   dtcd_pkg::dtcd_latch_type next_latchState;
   dtcd_pkg::dtcd_cmd_type next_runCommand;

   // preset path and bus
   logic [15:0] presetValue;
   logic [15:0] tableReadData;
   logic accessEnd;
   logic tableHit;
   logic [31:0] readMux;

   // address decode for the error answer only; the read mux decodes on its own
   function automatic logic regMapped(input logic [7:0] addr);
      return addr == dtcd_pkg::ADDR_CTRL || addr == dtcd_pkg::ADDR_FILTER ||
         addr == dtcd_pkg::ADDR_MAXFREQ || addr == dtcd_pkg::ADDR_STATUS ||
         addr == dtcd_pkg::ADDR_SELECT || addr == dtcd_pkg::ADDR_REF ||
         (addr[7:6] == dtcd_pkg::ADDR_TABLE_TOP && addr[1:0] == 2'h0);
   endfunction : regMapped

   // two flops before any logic sees a pin
   always_ff @(posedge clk) begin
      if (rst) begin
         syncFirst <= '0;
         syncSecond <= '0;
      end else begin
         syncFirst <= terminalIn;
         syncSecond <= syncFirst;
      end
   end

   // one millisecond time base for the filters
   always_ff @(posedge clk) begin
      if (rst) begin
         msCount <= 16'h0000;
         msTick <= 1'b0;
      end else if (msCount == 16'(MS_CYCLES - 1)) begin
         msCount <= 16'h0000;
         msTick <= 1'b1;
      end else begin
         msCount <= msCount + 16'h0001;
         msTick <= 1'b0;
      end
   end

   // stability counters; a level is taken one tick after the count
   // reaches the filter time, so up to a millisecond late, never early
   always_ff @(posedge clk) begin
      if (rst) begin
         filtered <= '0;
         for (int i = 0; i < NIN; i++) begin
            holdCount[i] <= 10'h000;
         end
      end else begin
         for (int i = 0; i < NIN; i++) begin
            if (syncSecond[i] == filtered[i]) begin
               holdCount[i] <= 10'h000;
            end else if (filterTime == 10'h000) begin
               filtered[i] <= syncSecond[i];
               holdCount[i] <= 10'h000;
            end else if (msTick) begin
               if (holdCount[i] >= filterTime) begin
                  filtered[i] <= syncSecond[i];
                  holdCount[i] <= 10'h000;
               end else begin
                  holdCount[i] <= holdCount[i] + 10'h001;
               end
            end
         end
      end
   end

   assign term = filtered;

   // switchover input promotes two-line mode 1 to three-line mode 1
   always_comb begin
      effMode = commandMode;
      if (commandMode == dtcd_pkg::MODE_TWO_1 && term.lineSwitch) begin
         effMode = dtcd_pkg::MODE_THREE_1;
      end
   end

   assign threeLine = effMode[1];

   // push edges come from the filtered levels, so bounce is already gone
   always_ff @(posedge clk) begin
      if (rst) begin
         prevRunFwd <= 1'b0;
         prevDirRev <= 1'b0;
      end else begin
         prevRunFwd <= term.runFwd;
         prevDirRev <= term.dirRev;
      end
   end

   assign fwdPress = term.runFwd & ~prevRunFwd;
   assign revPress = term.dirRev & ~prevDirRev;

   // three-line latch; forward wins when both pushes land together
   always_comb begin
      next_latchState = latchState;
      if (!threeLine || !term.enable) begin
         next_latchState = dtcd_pkg::LATCH_STOP;
      end else if (effMode == dtcd_pkg::MODE_THREE_1) begin
         if (fwdPress) begin
            next_latchState = dtcd_pkg::LATCH_FWD;
         end else if (revPress) begin
            next_latchState = dtcd_pkg::LATCH_REV;
         end
      end else begin
         case (latchState)
            dtcd_pkg::LATCH_STOP: begin
               if (fwdPress) begin
                  next_latchState = term.dirRev ? dtcd_pkg::LATCH_REV :
                     dtcd_pkg::LATCH_FWD;
               end
            end
            dtcd_pkg::LATCH_FWD, dtcd_pkg::LATCH_REV: begin
               // direction switch keeps steering a running drive
               next_latchState = term.dirRev ? dtcd_pkg::LATCH_REV :
                  dtcd_pkg::LATCH_FWD;
            end
            default: begin
               next_latchState = dtcd_pkg::LATCH_STOP;
            end
         endcase
      end
   end

   // latch holds after the pushes are released
   always_ff @(posedge clk) begin
      if (rst) begin
         latchState <= dtcd_pkg::LATCH_STOP;
      end else begin
         latchState <= next_latchState;
      end
   end

   // run command per mode
   always_comb begin
      logic forward_run_function;
      logic reverse_run_function;
      forward_run_function = 1'b0;
      reverse_run_function = 1'b0;
      case (effMode)
         dtcd_pkg::MODE_TWO_1: begin
            forward_run_function = term.runFwd & ~term.dirRev;
            reverse_run_function = term.dirRev & ~term.runFwd;
         end
         dtcd_pkg::MODE_TWO_2: begin
            forward_run_function = term.runFwd & ~term.dirRev;
            reverse_run_function = term.runFwd & term.dirRev;
         end
         default: begin
            forward_run_function = next_latchState == dtcd_pkg::LATCH_FWD;
            reverse_run_function = next_latchState == dtcd_pkg::LATCH_REV;
         end
      endcase
      next_runCommand.running = forward_run_function | reverse_run_function;
      next_runCommand.reverse = reverse_run_function;
      next_runCommand.forwardRun = forward_run_function;
      next_runCommand.reverseRun = reverse_run_function;
      next_runCommand.stop = ~(forward_run_function | reverse_run_function);
   end

   // command and selection outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         runCommand <= 5'h01;
         selection <= 8'h00;
      end else begin
         runCommand <= next_runCommand;
         selection.index <= term.refSel;
         selection.ramp <= term.rampSel;
         selection.motor <= term.motorSel;
      end
   end

   // preset table, port a follows the terminals, port b serves the bus
   dtcd_preset_mem presetStore (
      .clk(clk),
      .writeEn(accessEnd & pwrite & tableHit),
      .writeAddr(paddr[5:2]),
      .writeData(pwdata[15:0]),
      .readAddrA(term.refSel),
      .readDataA(presetValue),
      .readAddrB(paddr[5:2]),
      .readDataB(tableReadData)
   );

   // reference outputs, each gated by its source selection
   always_ff @(posedge clk) begin
      if (rst) begin
         refFrequency <= 16'h0000;
         pidSetpoint <= 16'h0000;
         vfVoltage <= 16'h0000;
      end else begin
         refFrequency <= freqSrcMulti ?
            dtcd_pkg::dtcd_scale(presetValue, maxFrequency) : 16'h0000;
         pidSetpoint <= pidSrcMulti ?
            dtcd_pkg::dtcd_clamp(presetValue) : 16'h0000;
         vfVoltage <= vfSrcMulti ?
            dtcd_pkg::dtcd_clamp(presetValue) : 16'h0000;
      end
   end

   assign accessEnd = psel & penable & pready;
   assign tableHit = paddr[7:6] == dtcd_pkg::ADDR_TABLE_TOP &&
      paddr[1:0] == 2'h0;

   // one wait state gives the table's registered read time to settle
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~regMapped(paddr);
      end
   end

   // register writes take effect at the completing edge only
   always_ff @(posedge clk) begin
      if (rst) begin
         commandMode <= dtcd_pkg::MODE_RESET;
         freqSrcMulti <= dtcd_pkg::CTRL_FREQ_RESET;
         pidSrcMulti <= dtcd_pkg::CTRL_PID_RESET;
         vfSrcMulti <= dtcd_pkg::CTRL_VF_RESET;
         filterTime <= dtcd_pkg::FILTER_RESET_MS;
         maxFrequency <= dtcd_pkg::MAXFREQ_RESET;
      end else if (accessEnd && pwrite) begin
         case (paddr)
            dtcd_pkg::ADDR_CTRL: begin
               commandMode <= pwdata[dtcd_pkg::CTRL_MODE_LSB +: 2];
               freqSrcMulti <= pwdata[dtcd_pkg::CTRL_FREQ_BIT];
               pidSrcMulti <= pwdata[dtcd_pkg::CTRL_PID_BIT];
               vfSrcMulti <= pwdata[dtcd_pkg::CTRL_VF_BIT];
            end
            dtcd_pkg::ADDR_FILTER: begin
               // out-of-range times saturate at one second
               filterTime <= (pwdata > 32'(dtcd_pkg::FILTER_MAX_MS)) ?
                  dtcd_pkg::FILTER_MAX_MS : pwdata[9:0];
            end
            dtcd_pkg::ADDR_MAXFREQ: begin
               maxFrequency <= pwdata[15:0];
            end
            default: begin
               filterTime <= filterTime;
            end
         endcase
      end
   end

   // read data mux
   always_comb begin
      readMux = 32'h0000_0000;
      if (tableHit) begin
         readMux = {16'h0000, tableReadData};
      end else begin
         case (paddr)
            dtcd_pkg::ADDR_CTRL: readMux = {27'h0, vfSrcMulti, pidSrcMulti,
               freqSrcMulti, commandMode};
            dtcd_pkg::ADDR_FILTER: readMux = {22'h0, filterTime};
            dtcd_pkg::ADDR_MAXFREQ: readMux = {16'h0000, maxFrequency};
            dtcd_pkg::ADDR_STATUS: readMux = {13'h0, runCommand, effMode,
               filtered};
            dtcd_pkg::ADDR_SELECT: readMux = {24'h0, selection};
            dtcd_pkg::ADDR_REF: readMux = {16'h0000, refFrequency};
            default: readMux = 32'h0000_0000;
         endcase
      end
   end

   // read data captured in the first access cycle and held after
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready && !pwrite) begin
         prdata <= readMux;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence threeLineDrop;
      threeLine && !term.enable;
   endsequence

   sequence fwdStartOne;
      effMode == dtcd_pkg::MODE_THREE_1 && term.enable && fwdPress;
   endsequence

   sequence runStartTwo;
      effMode == dtcd_pkg::MODE_THREE_2 && term.enable && fwdPress;
   endsequence

   select_index_a: assert property (
      selection.index == $past(filtered[3:0]) &&
      selection.ramp == $past(filtered[5:4]) &&
      selection.motor == $past(filtered[7:6]))
      else $error("selection does not follow filtered terminals");

   full_scale_a: assert property (
      $past(freqSrcMulti) && $past(presetValue) >= dtcd_pkg::PCT_FULL
      |-> refFrequency == $past(maxFrequency))
      else $error("full preset does not give maximum frequency");

   pid_source_a: assert property (
      !$past(pidSrcMulti) |-> pidSetpoint == 16'h0000)
      else $error("setpoint driven while its source is off");

   filter_tick_a: assert property (
      $changed(filtered) && $past(filterTime) != 10'h000 |-> $past(msTick))
      else $error("filtered level moved without a time-base tick");

   two_line_one_a: assert property (
      effMode == dtcd_pkg::MODE_TWO_1 && term.runFwd == term.dirRev
      |=> runCommand.stop)
      else $error("two-line mode 1 runs with both or no inputs");

   two_line_two_a: assert property (
      effMode == dtcd_pkg::MODE_TWO_2 && term.runFwd
      |=> runCommand.running && runCommand.reverse == $past(term.dirRev))
      else $error("two-line mode 2 direction wrong");

   enable_drop_a: assert property (
      threeLineDrop |=> runCommand.stop)
      else $error("three-line mode did not stop on enable off");

   fwd_push_a: assert property (
      fwdStartOne |=> runCommand.forwardRun)
      else $error("forward push did not start forward");

   run_push_a: assert property (
      runStartTwo |=> runCommand.running &&
      runCommand.reverse == $past(term.dirRev))
      else $error("run push started wrong direction");

   latch_hold_a: assert property (
      effMode == dtcd_pkg::MODE_THREE_1 &&
      $past(effMode) == dtcd_pkg::MODE_THREE_1 &&
      term.enable && !fwdPress && !revPress |=> $stable(runCommand))
      else $error("latched run state lost without a push");

   line_switch_a: assert property (
      commandMode == dtcd_pkg::MODE_TWO_1 && term.lineSwitch &&
      !term.enable |=> runCommand.stop)
      else $error("switchover did not select three-line mode 1");
endmodule : dtcd_top

// >>> hdl/dtcd_pkg.sv
// constants, types and helpers shared by the terminal command decoder
// Function
// - the four reference-select inputs form a binary index, the fourth as msb, choosing one of sixteen presets.
// - with multi-reference as frequency source, a preset of 100 percent equals the maximum output frequency.
// - the selected preset may also feed the process-loop setpoint or the separated v/f voltage.
// - two ramp-select inputs form a 2-bit index, second as msb, choosing ramp set 1 to 4.
// - two motor-select inputs form a 2-bit index, second as msb, choosing motor group 1 to 4.
// - every terminal is filtered with a programmable time from 0 to 1 s, 10 ms after reset.
// - the terminal command mode has four codes, two-line 1 and 2, three-line 1 and 2, reset to 0.
// - in two-line mode 1 forward alone runs forward, reverse alone runs reverse, both or none stop.
// - in two-line mode 2 run-enable runs, direction off forward and on reverse, enable off stops.
// - in three-line mode 1 with enable on, a forward push starts forward and a reverse push reverse.
// - in three-line mode 2 with enable on, a run push starts, direction input off forward, on reverse.
// - in both three-line modes the drive stops at once when the enable input goes off.
// - in three-line modes the run state is latched so released pushbuttons keep their effect.
// - the line-mode switchover input turns two-line mode 1 into three-line mode 1.
package dtcd_pkg;
   // timing
   localparam int CLK_HZ = 40_000_000;
   localparam int FILTER_UNIT_MS = 1;
   localparam int MS_CYCLES = CLK_HZ / 1000 * FILTER_UNIT_MS;
   localparam logic [9:0] FILTER_MAX_MS = 10'h3e8;
   localparam logic [9:0] FILTER_RESET_MS = 10'h00a;
   // terminal command modes
   localparam logic [1:0] MODE_TWO_1 = 2'h0;
   localparam logic [1:0] MODE_TWO_2 = 2'h1;
   localparam logic [1:0] MODE_THREE_1 = 2'h2;
   localparam logic [1:0] MODE_THREE_2 = 2'h3;
   localparam logic [1:0] MODE_RESET = 2'h0;
   // presets in 0.01 percent, frequency in 0.01 Hz
   localparam logic [15:0] PCT_FULL = 16'h2710;
   localparam logic [15:0] MAXFREQ_RESET = 16'h1388;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FILTER = 8'h04;
   localparam logic [7:0] ADDR_MAXFREQ = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_SELECT = 8'h10;
   localparam logic [7:0] ADDR_REF = 8'h14;
   localparam logic [1:0] ADDR_TABLE_TOP = 2'h1;
   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_FREQ_BIT = 2;
   localparam int CTRL_PID_BIT = 3;
   localparam int CTRL_VF_BIT = 4;
   localparam logic CTRL_FREQ_RESET = 1'h1;
   localparam logic CTRL_PID_RESET = 1'h0;
   localparam logic CTRL_VF_RESET = 1'h0;

   // filtered or raw terminal levels, high means on
   typedef struct packed {
      logic enable;
      logic lineSwitch;
      logic dirRev;
      logic runFwd;
      logic [1:0] motorSel;
      logic [1:0] rampSel;
      logic [3:0] refSel;
   } dtcd_term_type;

   // decoded run command
   typedef struct packed {
      logic running;
      logic reverse;
      logic forwardRun;
      logic reverseRun;
      logic stop;
   } dtcd_cmd_type;

   // decoded selections
   typedef struct packed {
      logic [1:0] motor;
      logic [1:0] ramp;
      logic [3:0] index;
   } dtcd_sel_type;

   // latched state of the three-line modes
   typedef enum logic [2:0] {
      LATCH_STOP = 3'b001,
      LATCH_FWD = 3'b010,
      LATCH_REV = 3'b100
   } dtcd_latch_type;

   // clamp a preset to 100 percent
   function automatic logic [15:0] dtcd_clamp(input logic [15:0] pct);
      return (pct > PCT_FULL) ? PCT_FULL : pct;
   endfunction : dtcd_clamp

   // scale a preset against the maximum frequency
   function automatic logic [15:0] dtcd_scale(input logic [15:0] pct,
                                              input logic [15:0] maxF);
      logic [31:0] prod;
      prod = 32'(dtcd_clamp(pct)) * 32'(maxF);
      return 16'(prod / 32'(PCT_FULL));
   endfunction : dtcd_scale
endpackage : dtcd_pkg

// >>> hdl/dtcd_preset_mem.sv
`timescale 1ns/1ps
// sixteen-word preset store with two registered read ports
module dtcd_preset_mem (
   // clock
   input wire logic clk,
   // write port
   input wire logic writeEn,
   input wire logic [3:0] writeAddr,
   input wire logic [15:0] writeData,
   // registered read ports
   input wire logic [3:0] readAddrA,
   output logic [15:0] readDataA,
   input wire logic [3:0] readAddrB,
   output logic [15:0] readDataB
);
   logic [15:0] store [16];

   // array holds no reset, software loads it before use
   always_ff @(posedge clk) begin
      if (writeEn) begin
         store[writeAddr] <= writeData;
      end
   end

   // read data come out of registers
   always_ff @(posedge clk) begin
      readDataA <= store[readAddrA];
      readDataB <= store[readAddrB];
   end
endmodule : dtcd_preset_mem

// >>> bench/dtcd_switches.sv
// behavioural switch panel standing in front of the terminal pins
`timescale 1ns/1ps
module dtcd_switches (
   // clock
   input wire logic clk,
   // operator contact levels and a contact bounce strobe
   input wire dtcd_pkg::dtcd_term_type want,
   input wire logic bounce,
   // contacts as the drive sees them
   output dtcd_pkg::dtcd_term_type pins
);
   // contacts follow the operator, each one clock later, enable included
   // a bounce flips every contact, so the filter sees a real glitch
   always_ff @(posedge clk) begin
      pins <= bounce ? ~want : want;
   end
endmodule : dtcd_switches

// >>> bench/tb_top.sv
// self-checking bench for the terminal command decoder
`timescale 1ns/1ps
module tb_top;
   localparam int MS = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic err;
   logic bounce = 1'b0;
   dtcd_pkg::dtcd_term_type want = '0;
   dtcd_pkg::dtcd_term_type pins;
   dtcd_pkg::dtcd_cmd_type runCommand;
   dtcd_pkg::dtcd_sel_type selection;
   logic [15:0] refFrequency;
   logic [15:0] pidSetpoint;
   logic [15:0] vfVoltage;
   int failures = 0;
   int compares = 0;
   // mode, {enable, lineSwitch, dirRev, runFwd}, expected command
   localparam logic [10:0] STEPS [25] = '{
      {2'h0, 4'h0, 5'h01}, {2'h0, 4'h1, 5'h14}, {2'h0, 4'h2, 5'h1a},
      {2'h0, 4'h3, 5'h01}, {2'h1, 4'h1, 5'h14}, {2'h1, 4'h3, 5'h1a},
      {2'h1, 4'h2, 5'h01}, {2'h1, 4'h0, 5'h01}, {2'h2, 4'h8, 5'h01},
      {2'h2, 4'h9, 5'h14}, {2'h2, 4'h8, 5'h14}, {2'h2, 4'ha, 5'h1a},
      {2'h2, 4'h8, 5'h1a}, {2'h2, 4'h0, 5'h01}, {2'h3, 4'h8, 5'h01},
      {2'h3, 4'h9, 5'h14}, {2'h3, 4'h8, 5'h14}, {2'h3, 4'ha, 5'h1a},
      {2'h3, 4'h2, 5'h01}, {2'h3, 4'ha, 5'h01}, {2'h3, 4'hb, 5'h1a},
      {2'h0, 4'h4, 5'h01}, {2'h0, 4'hd, 5'h14}, {2'h0, 4'hc, 5'h14},
      {2'h0, 4'h4, 5'h01}};

   dtcd_switches panel (.clk(clk), .want(want), .bounce(bounce),
                        .pins(pins));
   dtcd_top #(.MS_CYCLES(MS)) uut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .terminalIn(pins), .runCommand(runCommand), .selection(selection),
      .refFrequency(refFrequency), .pidSetpoint(pidSetpoint),
      .vfVoltage(vfVoltage));

   // free-running 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end

   // verdict and end of run, also reached from a timed-out wait
   task automatic final_report();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report

   // four-state compare of a seen value against its expectation
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // set the control contacts and wait out sync, filter and decode
   task automatic term(input logic [3:0] v);
      @(posedge clk);
      {want.enable, want.lineSwitch, want.dirRev, want.runFwd} <= v;
      repeat (10) @(posedge clk);
   endtask : term

   // main sequence
   initial begin
      int p;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, dtcd_pkg::ADDR_CTRL, 32'h0);
      check(rd, 32'h4);
      apb(1'b0, dtcd_pkg::ADDR_FILTER, 32'h0);
      check(rd, 32'ha);
      apb(1'b1, dtcd_pkg::ADDR_FILTER, 32'h7d0);
      apb(1'b0, dtcd_pkg::ADDR_FILTER, 32'h0);
      check(rd, 32'h3e8);
      apb(1'b0, 8'h20, 32'h0);
      check(32'(err), 32'h1);
      check(rd, 32'h0);
      apb(1'b1, dtcd_pkg::ADDR_FILTER, 32'h0);
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, 8'(8'h40 + 4 * i), 32'(i * 800));
      end
      apb(1'b1, dtcd_pkg::ADDR_CTRL, 32'h1c);
      // presets above 10000 clamp to full scale
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         want.refSel <= 4'(i);
         want.rampSel <= 2'(i);
         want.motorSel <= 2'(i >> 2);
         repeat (12) @(posedge clk);
         p = (i * 800 > 10000) ? 10000 : i * 800;
         check(32'(selection), 32'({2'(i >> 2), 2'(i), 4'(i)}));
         check(32'(refFrequency), 32'(p * 5000 / 10000));
         check(32'(pidSetpoint), 32'(p));
         check(32'(vfVoltage), 32'(p));
      end
      // new maximum frequency, other sources off, bus views of the result
      apb(1'b1, dtcd_pkg::ADDR_MAXFREQ, 32'hfa0);
      apb(1'b1, dtcd_pkg::ADDR_CTRL, 32'h4);
      repeat (4) @(posedge clk);
      check(32'(refFrequency), 32'hfa0);
      check(32'({pidSetpoint, vfVoltage}), 32'h0);
      apb(1'b0, dtcd_pkg::ADDR_REF, 32'h0);
      check(rd, 32'hfa0);
      apb(1'b0, dtcd_pkg::ADDR_SELECT, 32'h0);
      check(rd, 32'hff);
      apb(1'b0, 8'h7c, 32'h0);
      check(rd, 32'h2ee0);
      // stops compare only running and stop; a stop also clears reverse, forwardRun and reverseRun
      for (int i = 0; i < 25; i++) begin
         if (i == 0 || STEPS[i][10:9] != STEPS[i-1][10:9]) begin
            apb(1'b1, dtcd_pkg::ADDR_CTRL, 32'h1c | 32'(STEPS[i][10:9]));
         end
         term(STEPS[i][8:5]);
         if (STEPS[i][4:0] == 5'h01) begin
            check(32'({runCommand.running, runCommand.stop}), 32'h1);
         end else begin
            check(32'(runCommand), 32'(STEPS[i][4:0]));
         end
      end
      // 2 ms filter: a short glitch is dropped, a held level is taken
      apb(1'b1, dtcd_pkg::ADDR_FILTER, 32'h2);
      term(4'h0);
      @(posedge clk);
      bounce <= 1'b1;
      repeat (2) @(posedge clk);
      bounce <= 1'b0;
      repeat (20) @(posedge clk);
      check(32'({runCommand.running, runCommand.stop}), 32'h1);
      @(posedge clk);
      want.runFwd <= 1'b1;
      // a 2 ms level is not taken before two full ticks have passed
      repeat (10) @(posedge clk);
      check(32'({runCommand.running, runCommand.stop}), 32'h1);
      repeat (9) @(posedge clk);
      check(32'(runCommand), 32'h14);
      final_report();
   end
endmodule : tb_top
